// file: rtl/rpc_regulator_ctrl.v
/*
 rpc_regulator_ctrl: 8-bit regulator control register on the special-function bus.
 assumes a single-cycle sfr write/read strobe with address and data, synchronous inputs.
*/
`timescale 1ns/1ps
`include "rpc_map.vh"
module rpc_regulator_ctrl (
    // clock and reset
    input wire clk,
    input wire resetn,
    // special-function register bus
    input wire [7:0] sfr_addr,
    input wire sfr_wr,
    input wire sfr_rd,
    input wire [7:0] sfr_wdata,
    output reg [7:0] sfr_rdata_reg,
    output reg sfr_sel_reg,
    // system status inputs
    input wire bus_power_sense,
    input wire bus_power_irq_en,
    input wire stop_mode,
    input wire prefetch_en,
    input wire fetch_active,
    input wire clk_fast,
    // regulator and power outputs
    output reg input_reg_disable_reg,
    output reg input_reg_low_power_reg,
    output reg core_reg_low_power_reg,
    output reg core_reg_off_reg,
    output reg reset_pin_only_reg,
    output reg mem_power_on_reg,
    output reg mem_ready_reg,
    output reg core_lp_settled_reg,
    output reg bus_power_irq_reg
);
    reg stop_cfg_reg;
    reg mpc_en_reg;
    reg clk_fast_d_reg;
    reg [`RPC_SKIP_W-1:0] skip_cnt_reg;
    reg [`RPC_SETTLE_W-1:0] settle_cnt_reg;
    reg [7:0] ctl_value;
    reg [7:0] sfr_rdata_next;
    reg sfr_sel_next;
    reg input_reg_disable_next;
    reg input_reg_low_power_next;
    reg stop_cfg_next;
    reg core_reg_low_power_next;
    reg mpc_en_next;
    reg core_reg_off_next;
    reg [`RPC_SKIP_W-1:0] skip_cnt_next;
    reg mem_power_on_next;
    reg mem_ready_next;
    reg [`RPC_SETTLE_W-1:0] settle_cnt_next;
    reg core_lp_settled_next;
    reg bus_power_irq_next;
    wire bus_power_present;
    wire bus_power_edge;
    wire hit;
    wire access;
    wire fast_rise;
    wire mpc_active;
    wire skip_busy;

    rpc_edge_detect u_vbus (
        .clk(clk),
        .resetn(resetn),
        .level_in(bus_power_sense),
        .level_reg(bus_power_present),
        .edge_reg(bus_power_edge)
    );

    assign hit = (sfr_addr == `RPC_ADDR_REGCTL);
    assign access = hit && (sfr_rd || sfr_wr);
    assign mpc_active = mpc_en_reg && !prefetch_en;
    // rise of the fast-clock level while the controller may gate memory
    assign fast_rise = mpc_active && clk_fast && !clk_fast_d_reg;
    assign skip_busy = (skip_cnt_reg != {`RPC_SKIP_W{1'b0}});

    // read image: reserved bits stay zero, a one written there is dropped
    always @* begin
        ctl_value = 8'h00;
        ctl_value[`RPC_BIT_INPUT_DIS] = input_reg_disable_reg;
        ctl_value[`RPC_BIT_BUS_PWR] = bus_power_present;
        ctl_value[`RPC_BIT_RSVD_HI] = 1'b0;
        ctl_value[`RPC_BIT_INPUT_LP] = input_reg_low_power_reg;
        ctl_value[`RPC_BIT_STOP_CFG] = stop_cfg_reg;
        ctl_value[`RPC_BIT_RSVD_LO] = 1'b0;
        ctl_value[`RPC_BIT_CORE_LP] = core_reg_low_power_reg;
        ctl_value[`RPC_BIT_MPC_EN] = mpc_en_reg;
    end

    // other addresses read back zero and leave the register alone
    always @* begin
        sfr_sel_next = access;
        sfr_rdata_next = 8'h00;
        if (hit && sfr_rd)
            sfr_rdata_next = ctl_value;
    end

    // writable fields; a read in the same cycle still sees the old value
    always @* begin
        input_reg_disable_next = input_reg_disable_reg;
        input_reg_low_power_next = input_reg_low_power_reg;
        stop_cfg_next = stop_cfg_reg;
        core_reg_low_power_next = core_reg_low_power_reg;
        mpc_en_next = mpc_en_reg;
        if (hit && sfr_wr) begin
            input_reg_disable_next = sfr_wdata[`RPC_BIT_INPUT_DIS];
            input_reg_low_power_next = sfr_wdata[`RPC_BIT_INPUT_LP];
            stop_cfg_next = sfr_wdata[`RPC_BIT_STOP_CFG];
            // kept as written; misuse while input regulator is off is software's fault
            core_reg_low_power_next = sfr_wdata[`RPC_BIT_CORE_LP];
            mpc_en_next = sfr_wdata[`RPC_BIT_MPC_EN];
        end
    end

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            input_reg_disable_reg <= 1'b0;
            input_reg_low_power_reg <= 1'b0;
            stop_cfg_reg <= 1'b0;
            core_reg_low_power_reg <= 1'b0;
            mpc_en_reg <= 1'b0;
            sfr_rdata_reg <= `RPC_RESET_REGCTL;
            sfr_sel_reg <= 1'b0;
        end else begin
            input_reg_disable_reg <= input_reg_disable_next;
            input_reg_low_power_reg <= input_reg_low_power_next;
            stop_cfg_reg <= stop_cfg_next;
            core_reg_low_power_reg <= core_reg_low_power_next;
            mpc_en_reg <= mpc_en_next;
            sfr_rdata_reg <= sfr_rdata_next;
            sfr_sel_reg <= sfr_sel_next;
        end
    end

    // stop handling: core regulator off only with stop config set
    always @* begin
        core_reg_off_next = stop_mode && stop_cfg_reg;
    end

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            core_reg_off_reg <= 1'b0;
            reset_pin_only_reg <= 1'b0;
        end else begin
            core_reg_off_reg <= core_reg_off_next;
            // with the core regulator down only the pin reset can still act
            reset_pin_only_reg <= core_reg_off_next;
        end
    end

    // memory power and slow-to-fast settling skip
    always @* begin
        skip_cnt_next = skip_cnt_reg;
        if (fast_rise)
            skip_cnt_next = `RPC_SKIP_CLOCKS;
        else if (skip_busy)
            skip_cnt_next = skip_cnt_reg - 1'b1;
        // memory stays powered through the skip so the first read sees stable power
        mem_power_on_next = !mpc_active || fetch_active || skip_busy;
        mem_ready_next = !skip_busy;
    end

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            clk_fast_d_reg <= 1'b0;
            skip_cnt_reg <= {`RPC_SKIP_W{1'b0}};
            mem_power_on_reg <= 1'b1;
            mem_ready_reg <= 1'b1;
        end else begin
            clk_fast_d_reg <= clk_fast;
            skip_cnt_reg <= skip_cnt_next;
            mem_power_on_reg <= mem_power_on_next;
            mem_ready_reg <= mem_ready_next;
        end
    end

    // status aid for software: core low power held long enough to suspend oscillator;
    // the count saturates so a long suspend cannot wrap it back to zero
    always @* begin
        settle_cnt_next = settle_cnt_reg;
        if (!core_reg_low_power_reg)
            settle_cnt_next = {`RPC_SETTLE_W{1'b0}};
        else if (settle_cnt_reg != `RPC_CORE_SETTLE)
            settle_cnt_next = settle_cnt_reg + 1'b1;
        core_lp_settled_next = core_reg_low_power_reg &&
                               (settle_cnt_reg == `RPC_CORE_SETTLE);
    end

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            settle_cnt_reg <= {`RPC_SETTLE_W{1'b0}};
            core_lp_settled_reg <= 1'b0;
        end else begin
            settle_cnt_reg <= settle_cnt_next;
            core_lp_settled_reg <= core_lp_settled_next;
        end
    end

    // edge-sensitive event, no pending flag kept
    always @* begin
        bus_power_irq_next = bus_power_irq_en && bus_power_edge;
    end

    always @(posedge clk or negedge resetn) begin
        if (!resetn)
            bus_power_irq_reg <= 1'b0;
        else
            bus_power_irq_reg <= bus_power_irq_next;
    end
endmodule

// file: rtl/rpc_map.vh
/*
 regulator power control map: register address, bit positions, reset value and timing counts.
 assumes inclusion by the regulator power control design files only.
*/
`ifndef RPC_MAP_VH
`define RPC_MAP_VH
`define RPC_ADDR_REGCTL 8'hc9
`define RPC_RESET_REGCTL 8'h00
`define RPC_BIT_INPUT_DIS 7
`define RPC_BIT_BUS_PWR 6
`define RPC_BIT_RSVD_HI 5
`define RPC_BIT_INPUT_LP 4
`define RPC_BIT_STOP_CFG 3
`define RPC_BIT_RSVD_LO 2
`define RPC_BIT_CORE_LP 1
`define RPC_BIT_MPC_EN 0
`define RPC_SKIP_CLOCKS 5'h14
`define RPC_SKIP_W 5
`define RPC_CORE_SETTLE 4'hc
`define RPC_SETTLE_W 4
`endif

// file: rtl/rpc_edge_detect.v
/*
 rpc_edge_detect: one-cycle pulse on either edge of a synchronous input level.
 assumes the input is already synchronous to clk.
*/
`timescale 1ns/1ps
module rpc_edge_detect (
    // clock and reset
    input wire clk,
    input wire resetn,
    // level in, state and edge out
    input wire level_in,
    output reg level_reg,
    output reg edge_reg
);
    reg prev_reg;
    reg armed_reg;
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            prev_reg <= 1'b0;
            armed_reg <= 1'b0;
            level_reg <= 1'b0;
            edge_reg <= 1'b0;
        end else begin
            prev_reg <= level_in;
            // the first sample after reset has no history; an input already high
            // there is a level, not an edge
            armed_reg <= 1'b1;
            level_reg <= level_in;
            edge_reg <= armed_reg && (level_in ^ prev_reg);
        end
    end
endmodule

// file: verification/rpc_regulator_ctrl_asserts.sv
/* assertions on the rpc_regulator_ctrl ports.
 assumes binding by port name onto the design. */
`timescale 1ns/1ps
module rpc_ctrl_asserts (
    // clock and reset
    input wire clk,
    input wire resetn,
    // special-function register bus
    input wire sfr_wr,
    input wire sfr_rd,
    input wire [7:0] sfr_addr,
    input wire [7:0] sfr_wdata,
    input wire [7:0] sfr_rdata_reg,
    input wire sfr_sel_reg,
    // status inputs
    input wire bus_power_sense,
    input wire bus_power_irq_en,
    input wire stop_mode,
    input wire prefetch_en,
    input wire clk_fast,
    // regulator and power outputs
    input wire input_reg_disable_reg,
    input wire input_reg_low_power_reg,
    input wire core_reg_low_power_reg,
    input wire core_reg_off_reg,
    input wire reset_pin_only_reg,
    input wire mem_power_on_reg,
    input wire mem_ready_reg,
    input wire bus_power_irq_reg
);
    wire hit = sfr_addr == 8'hc9;
    reg mpc_reg;
    // shadow of bit 0, which no port shows
    always @(posedge clk or negedge resetn) begin
        if (!resetn)
            mpc_reg <= 1'b0;
        else if (sfr_wr && hit)
            mpc_reg <= sfr_wdata[0];
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence fast_rise; $rose(clk_fast) && mpc_reg && !prefetch_en; endsequence
    sequence skip_low; (!mem_ready_reg)[*8]; endsequence
    AST_SEL: assert property ((sfr_wr || sfr_rd) && hit |=> sfr_sel_reg)
        else $error("select pulse missing");
    AST_MISS: assert property (sfr_rd && !sfr_wr && !hit |=> sfr_rdata_reg == 8'h00)
        else $error("unmapped read not zero");
    AST_WR: assert property (sfr_wr && hit |=> {input_reg_disable_reg,
        input_reg_low_power_reg, core_reg_low_power_reg} == {$past(sfr_wdata[7]),
        $past(sfr_wdata[4]), $past(sfr_wdata[1])}) else $error("control bits wrong");
    AST_OFF: assert property (core_reg_off_reg |-> $past(stop_mode) && reset_pin_only_reg)
        else $error("core off outside stop");
    AST_PF: assert property (prefetch_en |=> mem_power_on_reg)
        else $error("memory off with prefetch");
    AST_MPC: assert property (!mpc_reg |=> mem_power_on_reg)
        else $error("memory off with controller disabled");
    AST_SKIP: assert property (fast_rise |-> ##[1:3] skip_low)
        else $error("no skip window");
    AST_IRQ: assert property ($changed(bus_power_sense) && bus_power_irq_en |->
        ##[1:3] bus_power_irq_reg) else $error("bus power event missing");
endmodule
bind rpc_regulator_ctrl rpc_ctrl_asserts u_chk (.*);

// file: verification/tb_top.sv
/* self-checking bench for rpc_regulator_ctrl.
 assumes the single-cycle strobe bus of the design. */
`timescale 1ns/1ps
module tb_top;
    logic clk, resetn, sfr_wr, sfr_rd, bus_power_sense, bus_power_irq_en;
    logic stop_mode, prefetch_en, fetch_active, clk_fast;
    logic [7:0] sfr_addr, sfr_wdata;
    wire [7:0] sfr_rdata_reg;
    wire sfr_sel_reg, input_reg_disable_reg, input_reg_low_power_reg, core_reg_low_power_reg;
    wire core_reg_off_reg, reset_pin_only_reg, mem_power_on_reg, mem_ready_reg;
    wire core_lp_settled_reg, bus_power_irq_reg;
    int n_errors, n_tests, cnt;
    rpc_regulator_ctrl DUT (.*);
    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        tick(1);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        tick(1);
        sfr_wr = 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        tick(1);
        sfr_addr = a;
        sfr_rd = 1'b1;
        tick(1);
        sfr_rd = 1'b0;
        chk("rdata", e, sfr_rdata_reg);
    endtask
    // counts event pulses over a window after a sense change
    task irq_count(input logic en, input logic s, input logic [7:0] e);
        bus_power_irq_en = en;
        bus_power_sense = s;
        cnt = 0;
        repeat (6) begin
            tick(1);
            if (bus_power_irq_reg === 1'b1) cnt++;
        end
        chk("irq", e, cnt);
    endtask
    task give_verdict;
        $display("errors %0d tests %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #200000;
        n_errors++;
        give_verdict;
    end
    initial begin
        {sfr_wr, sfr_rd, bus_power_sense, bus_power_irq_en, stop_mode, resetn} = '0;
        {prefetch_en, fetch_active, clk_fast, sfr_addr, sfr_wdata} = '0;
        repeat (12) @(posedge clk);
        #1 resetn = 1'b1;
        rd(8'hc9, 8'h00);
        chk("sel", 8'h01, sfr_sel_reg);
        bus_power_sense = 1'b1;
        // reserved bits written zero, core low power never with input regulator off
        wr(8'hc9, 8'h99);
        chk("ctl", 8'h06, {input_reg_disable_reg, input_reg_low_power_reg,
            core_reg_low_power_reg});
        rd(8'hc9, 8'hd9);
        rd(8'hc8, 8'h00);
        chk("sel", 8'h00, sfr_sel_reg);
        wr(8'hc9, 8'h00);
        rd(8'hc9, 8'h40);
        irq_count(1'b1, 1'b0, 8'h01);
        irq_count(1'b1, 1'b1, 8'h01);
        irq_count(1'b0, 1'b0, 8'h00);
        wr(8'hc9, 8'h12);
        chk("ctl", 8'h03, {input_reg_disable_reg, input_reg_low_power_reg,
            core_reg_low_power_reg});
        tick(12);
        chk("settled", 8'h00, core_lp_settled_reg);
        tick(1);
        chk("settled", 8'h01, core_lp_settled_reg);
        wr(8'hc9, 8'h08);
        stop_mode = 1'b1;
        tick(3);
        chk("core_off", 8'h03, {core_reg_off_reg, reset_pin_only_reg});
        wr(8'hc9, 8'h01);
        tick(3);
        chk("core_off", 8'h00, {core_reg_off_reg, reset_pin_only_reg});
        chk("mem_on", 8'h00, mem_power_on_reg);
        fetch_active = 1'b1;
        tick(2);
        chk("mem_on", 8'h01, mem_power_on_reg);
        fetch_active = 1'b0;
        clk_fast = 1'b1;
        cnt = 0;
        repeat (40) begin
            tick(1);
            if (mem_ready_reg === 1'b0 && mem_power_on_reg === 1'b1) cnt++;
        end
        chk("skip", 8'd20, cnt);
        prefetch_en = 1'b1;
        tick(2);
        chk("mem_on", 8'h01, mem_power_on_reg);
        // mid-run reset with the sense input already high: no event may follow
        resetn = 1'b0;
        bus_power_sense = 1'b1;
        tick(2);
        resetn = 1'b1;
        irq_count(1'b1, 1'b1, 8'h00);
        rd(8'hc9, 8'h40);
        give_verdict;
    end
endmodule
